// ==== spi_rx_dma_packer_bench.sv ====
`include "srdp_regs.svh"

module spi_rx_dma_packer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [63:0] words;
    logic [31:0] addr;
  } srdp_row_type;

  logic                     clk;
  logic                     sys_rst;
  srdp_pkg::srdp_link_type  link;
  logic                     slave_hold_off;
  logic [3:0]               reg_addr;
  logic [31:0]              reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [31:0]              reg_rdata;
  srdp_pkg::srdp_write_type mem_wr;
  logic                     half_block_done_irq;
  logic                     block_done_irq;
  srdp_pkg::srdp_write_type wq [$];
  srdp_pkg::srdp_write_type got;
  srdp_row_type             rows [32];
  logic [31:0]              rd;
  int                       half_cnt;
  int                       block_cnt;
  int                       hold_cnt;
  int                       fail_count;
  int                       samples_checked;

  srdp_top dut (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .link_in             (link),
    .slave_hold_off      (slave_hold_off),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .mem_wr              (mem_wr),
    .half_block_done_irq (half_block_done_irq),
    .block_done_irq      (block_done_irq)
  );

  srdp_master_model master (
    .clk            (clk),
    .slave_hold_off (slave_hold_off),
    .link           (link)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mem_wr.valid === 1'b1) wq.push_back(mem_wr);
    if (half_block_done_irq === 1'b1) half_cnt++;
    if (block_done_irq === 1'b1) block_cnt++;
    if (slave_hold_off === 1'b1) hold_cnt++;
  end

  task automatic check(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic expect_write(input logic [31:0] a, input logic [63:0] d);
    int n;
    n = 0;
    while (wq.size() == 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check(64'(wq.size()), 64'h0000_0000_0000_0001);
    if (wq.size() != 0) begin
      got = wq.pop_front();
      check({32'h0000_0000, got.addr}, {32'h0000_0000, a});
      check(got.data, d);
    end
  endtask

  task automatic send_row(input int i, input logic par, input logic odd);
    for (int k = 0; k < 4; k++) master.send_word(rows[i].words[16*k +: 16], par, odd, 1'b0);
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 4; k++) rows[i].words[16*k +: 16] = {8'(i), 4'hA ^ 4'(k), 4'(k)};
      rows[i].addr = 32'h0000_1000 + 32'(8 * (i % 2)) + 32'(16 * (i / 2));
    end
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    reg_read(`SRDP_ADDR_CTRL, rd);
    check({32'h0, rd}, 64'h0);
    reg_read(`SRDP_ADDR_STATUS, rd);
    check({32'h0, rd}, 64'h0);
    reg_read(4'hF, rd);
    check({32'h0, rd}, 64'h0);
    reg_write(`SRDP_ADDR_DST_BASE, 32'h0000_1007);
    reg_read(`SRDP_ADDR_DST_BASE, rd);
    check({32'h0, rd}, 64'h0000_0000_0000_1000);
    $display("test registers done");
    reg_write(`SRDP_ADDR_CTRL, 32'h0000_0005);
    master.begin_block();
    for (int i = 0; i < 32; i++) begin
      send_row(i, 1'b0, 1'b0);
      expect_write(rows[i].addr, rows[i].words);
      if (i == 15) check(64'(half_cnt), 64'h1);
    end
    master.end_block();
    check(64'(block_cnt), 64'h1);
    check(64'(hold_cnt != 0), 64'h1);
    $display("test block done");
    reg_read(`SRDP_ADDR_STATUS, rd);
    check({32'h0, rd}, 64'h3);
    reg_read(`SRDP_ADDR_BLOCK_CNT, rd);
    check({32'h0, rd}, 64'h2);
    reg_write(`SRDP_ADDR_STATUS, 32'h0000_0003);
    reg_read(`SRDP_ADDR_STATUS, rd);
    check({32'h0, rd}, 64'h0);
    $display("test status done");
    hold_cnt = 0;
    reg_write(`SRDP_ADDR_CTRL, 32'h0000_000B);
    master.begin_block();
    send_row(3, 1'b1, 1'b1);
    expect_write(rows[0].addr, rows[3].words);
    master.send_word(16'h1234, 1'b1, 1'b1, 1'b1);
    master.end_block();
    reg_read(`SRDP_ADDR_STATUS, rd);
    check({32'h0, rd & 32'h0000_0008}, 64'h8);
    check(64'(hold_cnt), 64'h0);
    reg_read(`SRDP_ADDR_FRAME_CNT, rd);
    check({32'h0, rd}, 64'h0000_0000_0000_0B01);
    $display("test parity done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({mem_wr.valid, half_block_done_irq, block_done_irq, slave_hold_off}, 64'h0);
    check({mem_wr.addr, reg_rdata}, 64'h0);
    check(mem_wr.data, 64'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    wq.delete();
    reg_write(`SRDP_ADDR_CTRL, 32'h0000_0001);
    master.begin_block();
    master.nibble(4'h9);
    master.nibble(4'h6);
    master.end_block();
    master.begin_block();
    send_row(5, 1'b0, 1'b0);
    expect_write(32'h0000_0000, rows[5].words);
    reg_write(`SRDP_ADDR_CTRL, 32'h0000_0000);
    for (int k = 0; k < 9; k++) master.send_word(16'(k), 1'b0, 1'b0, 1'b0);
    master.end_block();
    reg_read(`SRDP_ADDR_STATUS, rd);
    check({32'h0, rd}, 64'h4);
    check(64'(wq.size()), 64'h0);
    $display("test reset and partial word done");
    give_verdict();
  end
endmodule

// ==== srdp_link_rx.sv ====
`include "srdp_regs.svh"

module srdp_link_rx (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire srdp_pkg::srdp_link_type link_in,
  input  wire srdp_pkg::srdp_ctrl_type ctrl,
  output logic                       word_valid,
  output logic [15:0]                word_data,
  output logic                       parity_err,
  output logic                       cs_active
);

  // ****************************************
  // two-flop synchroniser
  // ****************************************
  srdp_pkg::srdp_link_type meta_r, sync_r, last_r;
  logic [2:0]  nib_r, nib_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic        vld_r, vld_nxt;
  logic [15:0] data_r, data_nxt;
  logic        perr_r, perr_nxt;
  logic        rise;
  logic [2:0]  need;

  function automatic logic calc_parity(input logic [15:0] d, input logic odd);
    calc_parity = (^d) ^ odd;
  endfunction

  always_comb begin
    rise      = sync_r.sclk & ~last_r.sclk & ~sync_r.cs_n;
    // [R16] parity adds a clock
    need      = ctrl.parity ? `SRDP_NIBBLES_PARITY : `SRDP_NIBBLES_DATA;
    nib_nxt   = nib_r;
    shift_nxt = shift_r;
    vld_nxt   = 1'b0;
    data_nxt  = data_r;
    perr_nxt  = 1'b0;
    if (sync_r.cs_n) begin
      nib_nxt = 3'h0;
    end else if (rise) begin
      // [R14] four bits per clock
      if (nib_r < `SRDP_NIBBLES_DATA) begin
        shift_nxt = {shift_r[11:0], sync_r.parallel_out_lanes};
      end
      if (nib_r + 3'h1 == need) begin
        nib_nxt  = 3'h0;
        vld_nxt  = 1'b1;
        data_nxt = (nib_r < `SRDP_NIBBLES_DATA) ?
                   {shift_r[11:0], sync_r.parallel_out_lanes} : shift_r;
        perr_nxt = ctrl.parity &&
                   (calc_parity(shift_r, ctrl.odd_parity) != sync_r.parallel_out_lanes[3]);
      end else begin
        nib_nxt = nib_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r  <= '{sclk: 1'b0, cs_n: 1'b1, parallel_out_lanes: 4'h0};
      sync_r  <= '{sclk: 1'b0, cs_n: 1'b1, parallel_out_lanes: 4'h0};
      last_r  <= '{sclk: 1'b0, cs_n: 1'b1, parallel_out_lanes: 4'h0};
      nib_r   <= 3'h0;
      shift_r <= 16'h0000;
      vld_r   <= 1'b0;
      data_r  <= 16'h0000;
      perr_r  <= 1'b0;
    end else begin
      meta_r  <= link_in;
      sync_r  <= meta_r;
      last_r  <= sync_r;
      nib_r   <= nib_nxt;
      shift_r <= shift_nxt;
      vld_r   <= vld_nxt;
      data_r  <= data_nxt;
      perr_r  <= perr_nxt;
    end
  end

  assign word_valid = vld_r;
  assign word_data  = data_r;
  assign parity_err = perr_r;
  assign cs_active  = ~sync_r.cs_n;

endmodule

// ==== srdp_master_model.sv ====
// ****************************************
// four-lane link master
// ****************************************
module srdp_master_model #(
  parameter int HALF = 8
) (
  input  wire logic               clk,
  input  wire logic               slave_hold_off,
  output srdp_pkg::srdp_link_type link
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last_r;

  initial begin
    link = '0;
    link.cs_n = 1'b1;
    link.parallel_out_lanes = 4'hF;
    last_r = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic nibble(input logic [3:0] v);
    link.parallel_out_lanes <= v;
    last_r <= v;
    tick(HALF);
    link.sclk <= 1'b1;
    tick(HALF);
    link.sclk <= 1'b0;
  endtask

  // select held low over a block
  task automatic begin_block();
    @(posedge clk);
    link.cs_n <= 1'b0;
    tick(HALF);
  endtask

  task automatic end_block();
    tick(HALF);
    link.cs_n <= 1'b1;
    link.parallel_out_lanes <= ~last_r;
  endtask

  task automatic send_word(input logic [15:0] d, input logic par, input logic odd, input logic flip);
    int w;
    w = 0;
    // wait while the slave holds off
    while (slave_hold_off === 1'b1 && w < 2000) begin
      tick(1);
      w++;
    end
    for (int i = 3; i >= 0; i--) nibble(d[4*i +: 4]);
    if (par) nibble({(^d) ^ odd ^ flip, 3'b000});
  endtask
endmodule

// ==== srdp_pkg.sv ====
package srdp_pkg;

  typedef struct packed {
    logic        sclk;
    logic        cs_n;
    logic [3:0]  parallel_out_lanes;
  } srdp_link_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [63:0] data;
  } srdp_write_type;

  typedef struct packed {
    logic        enable;
    logic        parity;
    logic        hold_en;
    logic        odd_parity;
  } srdp_ctrl_type;

  typedef enum logic [1:0] {
    SRDP_IDLE = 2'b00,
    SRDP_READ = 2'b01,
    SRDP_PACK = 2'b11
  } srdp_dma_state_type;

endpackage

// ==== srdp_regs.svh ====
`ifndef SRDP_REGS_SVH
`define SRDP_REGS_SVH

// register offsets (word addresses on the plain port)
`define SRDP_ADDR_CTRL        4'h0
`define SRDP_ADDR_STATUS      4'h1
`define SRDP_ADDR_DST_BASE    4'h2
`define SRDP_ADDR_FRAME_CNT   4'h3
`define SRDP_ADDR_BLOCK_CNT   4'h4

// control fields
`define SRDP_CTRL_ENABLE      0
`define SRDP_CTRL_PARITY      1
`define SRDP_CTRL_HOLD_EN     2
`define SRDP_CTRL_ODD_PARITY  3
`define SRDP_CTRL_RESET_VAL   4'h0

// status fields, write one to clear
`define SRDP_STAT_HALF        0
`define SRDP_STAT_BLOCK       1
`define SRDP_STAT_OVERFLOW    2
`define SRDP_STAT_PARITY_ERR  3

// transfer geometry
`define SRDP_RX_BUFFERS       8
`define SRDP_ELEMS_PER_FRAME  4
`define SRDP_FRAMES_PER_PKT   16
`define SRDP_HALF_FRAMES      8
`define SRDP_SRC_START        8'h02
`define SRDP_SRC_ELEM_STEP    8'h04
`define SRDP_SRC_FRAME_STEP   8'h00
`define SRDP_DST_ELEM_STEP    32'h0000_0000
`define SRDP_DST_FRAME_STEP   32'h0000_0010
`define SRDP_DST_PKT_OFFSET   32'h0000_0008
`define SRDP_NIBBLES_DATA     3'h4
`define SRDP_NIBBLES_PARITY   3'h5
`define SRDP_DST_BASE_RESET   32'h0000_0000

`endif

// ==== srdp_rx_ram.sv ====
`include "srdp_regs.svh"

module srdp_rx_ram (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic [7:0]  rd_addr,
  input  wire logic        rd_en,
  output logic [15:0]      rd_data,
  output logic             overflow,
  output logic             half_ready,
  output logic [2:0]       wr_index
);

  // ****************************************
  // eight 32-bit entries: status high, data low
  // ****************************************
  logic [31:0] mem_r   [`SRDP_RX_BUFFERS];
  logic [31:0] mem_nxt [`SRDP_RX_BUFFERS];
  logic [7:0]  fresh_r, fresh_nxt;
  logic [2:0]  wi_r, wi_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic        ovf_r, ovf_nxt;
  logic        half_r, half_nxt;
  logic [2:0]  ri;

  always_comb begin
    ri        = rd_addr[4:2];
    mem_nxt   = mem_r;
    fresh_nxt = fresh_r;
    wi_nxt    = wi_r;
    rd_nxt    = rd_r;
    ovf_nxt   = 1'b0;
    half_nxt  = 1'b0;
    if (rd_en) begin
      // [R1] data half only
      rd_nxt = mem_r[ri][15:0];
      fresh_nxt[ri] = 1'b0;
    end
    if (wr_en) begin
      // [R22] unread entry overwritten
      ovf_nxt = fresh_r[wi_r] & ~(rd_en && ri == wi_r);
      mem_nxt[wi_r] = {15'h0000, fresh_r[wi_r], wr_data};
      fresh_nxt[wi_r] = 1'b1;
      wi_nxt = wi_r + 3'h1;
      // [R19] request per filled half
      half_nxt = (wi_r[1:0] == 2'h3);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `SRDP_RX_BUFFERS; i++) begin
        mem_r[i] <= 32'h0000_0000;
      end
      fresh_r <= 8'h00;
      wi_r    <= 3'h0;
      rd_r    <= 16'h0000;
      ovf_r   <= 1'b0;
      half_r  <= 1'b0;
    end else begin
      mem_r   <= mem_nxt;
      fresh_r <= fresh_nxt;
      wi_r    <= wi_nxt;
      rd_r    <= rd_nxt;
      ovf_r   <= ovf_nxt;
      half_r  <= half_nxt;
    end
  end

  assign rd_data    = rd_r;
  assign overflow   = ovf_r;
  assign half_ready = half_r;
  assign wr_index   = wi_r;

endmodule

// ==== srdp_top.sv ====
`include "srdp_regs.svh"

// Behaviour
// [R1] each buffer read fetches only the sixteen-bit data half
// [R2] four received words pack into one 64-bit memory write
// [R3] a frame reads four elements, one per buffer of its half
// [R4] a packet runs sixteen frames, 128 bytes
// [R5] one request moves one whole frame
// [R6] source steps four bytes between elements
// [R7] source frame step is zero, same four buffers each frame
// [R8] destination element step is zero
// [R9] destination steps sixteen bytes per frame, packets interleave
// [R10] both address generators are indexed
// [R11] two packets alternate over buffer halves, 256 bytes total
// [R12] second packet flags half block done after eight frames
// [R13] second packet flags block done after sixteen frames
// [R14] a sixteen-bit frame arrives as four nibbles on four lanes
// [R15] hold-off raised while busy, dropped when ready
// [R16] parity adds a fifth clock carrying one bit
// [R17] master keeps chip select low through a block
// [R18] eight buffers must be drained before overflow
// [R19] request raised after each half of the buffer group fills
// [R20] read pointer starts at byte offset two
// [R21] earliest word sits in the lowest lane
// [R22] overwrite of an unread buffer flags overflow
module srdp_top (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire srdp_pkg::srdp_link_type link_in,
  output logic                         slave_hold_off,
  input  wire logic [3:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata,
  output srdp_pkg::srdp_write_type     mem_wr,
  output logic                         half_block_done_irq,
  output logic                         block_done_irq
);

  // ****************************************
  // declarations
  // ****************************************
  srdp_pkg::srdp_ctrl_type     ctrl_r, ctrl_nxt;
  logic [31:0]                 dst_base_r, dst_base_nxt;
  logic [3:0]                  stat_r, stat_nxt;
  logic [31:0]                 rdata_r, rdata_nxt;
  logic [7:0]                  blk_cnt_r, blk_cnt_nxt;
  srdp_pkg::srdp_dma_state_type st_r, st_nxt;
  logic [1:0]                  req_r, req_nxt;
  logic                        pkt_r, pkt_nxt;
  logic [3:0]                  frame_r [2];
  logic [3:0]                  frame_nxt [2];
  logic [1:0]                  elem_r, elem_nxt;
  logic [7:0]                  src_r, src_nxt;
  logic [63:0]                 pack_r, pack_nxt;
  logic                        rd_pend_r, rd_pend_nxt;
  srdp_pkg::srdp_write_type    wr_r, wr_nxt;
  logic                        hold_r, hold_nxt;
  logic                        hbc_r, hbc_nxt;
  logic                        btc_r, btc_nxt;
  logic                        word_valid;
  logic [15:0]                 word_data;
  logic                        parity_err;
  logic                        cs_active;
  logic [15:0]                 ram_rdata;
  logic                        ram_ovf;
  logic                        half_ready;
  logic [2:0]                  wr_index;
  logic                        rd_en;

  function automatic logic [31:0] dst_addr(input logic [31:0] base, input logic pkt, input logic [3:0] frm);
    // [R9] interleaved 16-byte stride
    dst_addr = base + (pkt ? `SRDP_DST_PKT_OFFSET : 32'h0000_0000)
             + `SRDP_DST_ELEM_STEP + ({28'h000_0000, frm} * `SRDP_DST_FRAME_STEP);
  endfunction

  function automatic logic [7:0] src_first(input logic pkt);
    // [R20] data half at offset two, [R11] second half at entry four
    src_first = `SRDP_SRC_START + (pkt ? 8'h10 : 8'h00);
  endfunction

  // ****************************************
  // link receiver and buffer RAM
  // ****************************************
  srdp_link_rx u_link (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .link_in    (link_in),
    .ctrl       (ctrl_r),
    .word_valid (word_valid),
    .word_data  (word_data),
    .parity_err (parity_err),
    .cs_active  (cs_active)
  );

  srdp_rx_ram u_ram (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .wr_en      (word_valid),
    .wr_data    (word_data),
    .rd_addr    (src_r),
    .rd_en      (rd_en),
    .rd_data    (ram_rdata),
    .overflow   (ram_ovf),
    .half_ready (half_ready),
    .wr_index   (wr_index)
  );

  // ****************************************
  // register port
  // ****************************************
  always_comb begin
    ctrl_nxt     = ctrl_r;
    dst_base_nxt = dst_base_r;
    stat_nxt     = stat_r;
    if (reg_wr) begin
      case (reg_addr)
        `SRDP_ADDR_CTRL: begin
          ctrl_nxt = '{enable:     reg_wdata[`SRDP_CTRL_ENABLE],
                       parity:     reg_wdata[`SRDP_CTRL_PARITY],
                       hold_en:    reg_wdata[`SRDP_CTRL_HOLD_EN],
                       odd_parity: reg_wdata[`SRDP_CTRL_ODD_PARITY]};
        end
        `SRDP_ADDR_STATUS: stat_nxt = stat_r & ~reg_wdata[3:0];
        `SRDP_ADDR_DST_BASE: dst_base_nxt = {reg_wdata[31:3], 3'h0};
        default: begin
        end
      endcase
    end
    // set wins over clear
    if (hbc_nxt) begin
      stat_nxt[`SRDP_STAT_HALF] = 1'b1;
    end
    if (btc_nxt) begin
      stat_nxt[`SRDP_STAT_BLOCK] = 1'b1;
    end
    if (ram_ovf) begin
      stat_nxt[`SRDP_STAT_OVERFLOW] = 1'b1;
    end
    if (parity_err) begin
      stat_nxt[`SRDP_STAT_PARITY_ERR] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r     <= '{enable: 1'b0, parity: 1'b0, hold_en: 1'b0, odd_parity: 1'b0};
      dst_base_r <= `SRDP_DST_BASE_RESET;
      stat_r     <= 4'h0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      dst_base_r <= dst_base_nxt;
      stat_r     <= stat_nxt;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `SRDP_ADDR_CTRL: rdata_nxt = {28'h000_0000, ctrl_r.odd_parity, ctrl_r.hold_en,
                                      ctrl_r.parity, ctrl_r.enable};
        `SRDP_ADDR_STATUS: rdata_nxt = {28'h000_0000, stat_r};
        `SRDP_ADDR_DST_BASE: rdata_nxt = dst_base_r;
        `SRDP_ADDR_FRAME_CNT: rdata_nxt = {20'h0_0000, wr_index, pkt_r, frame_r[1], frame_r[0]};
        `SRDP_ADDR_BLOCK_CNT: rdata_nxt = {24'h00_0000, blk_cnt_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // frame-transfer DMA
  // ****************************************
  always_comb begin
    st_nxt      = st_r;
    req_nxt     = req_r;
    pkt_nxt     = pkt_r;
    frame_nxt   = frame_r;
    elem_nxt    = elem_r;
    src_nxt     = src_r;
    pack_nxt    = pack_r;
    rd_pend_nxt = 1'b0;
    wr_nxt      = '{valid: 1'b0, addr: wr_r.addr, data: wr_r.data};
    hbc_nxt     = 1'b0;
    btc_nxt     = 1'b0;
    blk_cnt_nxt = blk_cnt_r;
    rd_en       = 1'b0;
    // [R19] half-filled request, one per half
    if (half_ready && ctrl_r.enable) begin
      req_nxt[wr_index[2] ? 1'b0 : 1'b1] = 1'b1;
    end
    if (rd_pend_r) begin
      // [R21] earliest word lowest
      pack_nxt = {ram_rdata, pack_r[63:16]};
    end
    case (st_r)
      srdp_pkg::SRDP_IDLE: begin
        // [R11] alternate packets
        if (req_r[pkt_r]) begin
          req_nxt[pkt_r] = 1'b0;
          // [R7] [R10] indexed, frame step zero
          src_nxt  = src_first(pkt_r) + `SRDP_SRC_FRAME_STEP;
          elem_nxt = 2'h0;
          st_nxt   = srdp_pkg::SRDP_READ;
        end
      end
      srdp_pkg::SRDP_READ: begin
        // [R5] [R3] four reads per request
        rd_en       = 1'b1;
        rd_pend_nxt = 1'b1;
        // [R6] four-byte element step
        src_nxt  = src_r + `SRDP_SRC_ELEM_STEP;
        elem_nxt = elem_r + 2'h1;
        if (elem_r == 2'(`SRDP_ELEMS_PER_FRAME - 1)) begin
          st_nxt = srdp_pkg::SRDP_PACK;
        end
      end
      srdp_pkg::SRDP_PACK: begin
        if (!rd_pend_r) begin
          // [R2] [R8] single 64-bit write
          wr_nxt = '{valid: 1'b1, addr: dst_addr(dst_base_r, pkt_r, frame_r[pkt_r]), data: pack_r};
          // [R4] sixteen frames per packet
          frame_nxt[pkt_r] = frame_r[pkt_r] + 4'h1;
          if (pkt_r) begin
            // [R12] after eight frames
            if (frame_r[1] == 4'(`SRDP_HALF_FRAMES - 1)) begin
              hbc_nxt = 1'b1;
            end
            // [R13] after sixteen frames
            if (frame_r[1] == 4'(`SRDP_FRAMES_PER_PKT - 1)) begin
              btc_nxt = 1'b1;
            end
          end
          if (hbc_nxt | btc_nxt) begin
            blk_cnt_nxt = blk_cnt_r + 8'h01;
          end
          pkt_nxt = ~pkt_r;
          st_nxt  = srdp_pkg::SRDP_IDLE;
        end
      end
      default: st_nxt = srdp_pkg::SRDP_IDLE;
    endcase
    // [R15] [R18] hold off while a half awaits draining
    hold_nxt = ctrl_r.hold_en && cs_active && (req_nxt != 2'b00 || st_nxt != srdp_pkg::SRDP_IDLE);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blk_cnt_r  <= 8'h00;
      st_r       <= srdp_pkg::SRDP_IDLE;
      req_r      <= 2'b00;
      pkt_r      <= 1'b0;
      frame_r[0] <= 4'h0;
      frame_r[1] <= 4'h0;
      elem_r     <= 2'h0;
      src_r      <= `SRDP_SRC_START;
      pack_r     <= 64'h0000_0000_0000_0000;
      rd_pend_r  <= 1'b0;
      wr_r       <= '{valid: 1'b0, addr: 32'h0000_0000, data: 64'h0000_0000_0000_0000};
      hold_r     <= 1'b0;
      hbc_r      <= 1'b0;
      btc_r      <= 1'b0;
    end else begin
      blk_cnt_r  <= blk_cnt_nxt;
      st_r       <= st_nxt;
      req_r      <= req_nxt;
      pkt_r      <= pkt_nxt;
      frame_r    <= frame_nxt;
      elem_r     <= elem_nxt;
      src_r      <= src_nxt;
      pack_r     <= pack_nxt;
      rd_pend_r  <= rd_pend_nxt;
      wr_r       <= wr_nxt;
      hold_r     <= hold_nxt;
      hbc_r      <= hbc_nxt;
      btc_r      <= btc_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata           = rdata_r;
  assign mem_wr              = wr_r;
  assign slave_hold_off      = hold_r;
  assign half_block_done_irq = hbc_r;
  assign block_done_irq      = btc_r;

endmodule

// ==== srdp_top_properties.sv ====
`include "srdp_regs.svh"

// ****************************************
// packing and event checker
// ****************************************
module srdp_top_properties (
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic [3:0]               reg_addr,
  input wire logic [31:0]              reg_wdata,
  input wire logic                     reg_wr,
  input wire srdp_pkg::srdp_write_type mem_wr,
  input wire logic                     half_block_done_irq,
  input wire logic                     block_done_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] base_r;
  logic [31:0] base_nxt;
  logic [31:0] off;
  logic        bank_r;
  logic        bank_nxt;
  logic [3:0]  frm0_r;
  logic [3:0]  frm0_nxt;
  logic [3:0]  frm1_r;
  logic [3:0]  frm1_nxt;
  logic [3:0]  cur_frm;

  assign off = mem_wr.addr - base_r;
  assign cur_frm = bank_r ? frm1_r : frm0_r;

  // expected packet and frame of the next write
  always_comb begin
    base_nxt = base_r;
    bank_nxt = bank_r;
    frm0_nxt = frm0_r;
    frm1_nxt = frm1_r;
    if (reg_wr && reg_addr == `SRDP_ADDR_DST_BASE) begin
      base_nxt = {reg_wdata[31:3], 3'b000};
    end
    if (mem_wr.valid) begin
      bank_nxt = ~bank_r;
      frm0_nxt = bank_r ? frm0_r : frm0_r + 4'h1;
      frm1_nxt = bank_r ? frm1_r + 4'h1 : frm1_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_r <= `SRDP_DST_BASE_RESET;
      bank_r <= 1'b0;
      frm0_r <= 4'h0;
      frm1_r <= 4'h0;
    end else begin
      base_r <= base_nxt;
      bank_r <= bank_nxt;
      frm0_r <= frm0_nxt;
      frm1_r <= frm1_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence quiet_gap;
    !mem_wr.valid [*5];
  endsequence

  write_spacing_a : assert property (mem_wr.valid |=> quiet_gap)
    else $error("two packed writes closer than one frame");
  write_align_a : assert property (mem_wr.valid |-> mem_wr.addr[2:0] == 3'b000)
    else $error("packed write not on an 8-byte slot");
  pkt_alternate_a : assert property (mem_wr.valid |-> off[3] == bank_r)
    else $error("packets do not alternate");
  dst_step_a : assert property (mem_wr.valid |-> off[7:4] == cur_frm)
    else $error("destination frame step wrong");
  region_bound_a : assert property (mem_wr.valid |-> off[31:8] == 24'h00_0000)
    else $error("write outside the two regions");
  half_irq_a : assert property (half_block_done_irq |-> mem_wr.valid && bank_r && frm1_r == 4'h7)
    else $error("half block event at wrong frame");
  half_cause_a : assert property (mem_wr.valid && bank_r && frm1_r == 4'h7 |-> half_block_done_irq)
    else $error("half block event missing");
  block_irq_a : assert property (block_done_irq |-> mem_wr.valid && bank_r && frm1_r == 4'hF)
    else $error("block event at wrong frame");
  block_cause_a : assert property (mem_wr.valid && bank_r && frm1_r == 4'hF |-> block_done_irq)
    else $error("block event missing");
endmodule

bind srdp_top srdp_top_properties chk (
  .clk                 (clk),
  .sys_rst             (sys_rst),
  .reg_addr            (reg_addr),
  .reg_wdata           (reg_wdata),
  .reg_wr              (reg_wr),
  .mem_wr              (mem_wr),
  .half_block_done_irq (half_block_done_irq),
  .block_done_irq      (block_done_irq)
);
